// file: rtl/tbs_top.sv
`timescale 1ns/100ps
`include "tbs_consts.svh"
module tbs_top (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [11:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [4:0]         int_pulse,
  input  wire logic [11:0]        external_pulse_inputs,
  input  tbs_pkg::tbs_date_s      rtc_date,
  output logic      [2:0]         active_tariff,
  output logic                    log_strobe,
  output logic      [19:0]        log_fields,
  output logic      [3:0]         log_sections,
  output logic      [3:0]         log_tariffs
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations and helpers.

  function automatic logic is_int(input logic [4:0] s);
    return (s >= `TBS_SRC_INT_LO) && (s <= `TBS_SRC_INT_HI);
  endfunction : is_int

  function automatic logic is_ext(input logic [4:0] s);
    return (s >= `TBS_SRC_EXT_LO) && (s <= `TBS_SRC_EXT_HI);
  endfunction : is_ext

  function automatic tbs_pkg::tbs_unit_e auto_unit(input logic [4:0] s);
    if (s <= 5'h02) return tbs_pkg::TBS_U_KWH;
    if (s <= 5'h04) return tbs_pkg::TBS_U_KVARH;
    return tbs_pkg::TBS_U_KVAH;
  endfunction : auto_unit

  tbs_pkg::tbs_cfg_s   cfg_r    [`TBS_NREG];
  tbs_pkg::tbs_cfg_s   cfg_nxt  [`TBS_NREG];
  logic [31:0]         part_r   [`TBS_NFILE];
  logic [31:0]         part_nxt [`TBS_NFILE];
  tbs_pkg::tbs_cal_s   cal_r    [`TBS_NCAL];
  tbs_pkg::tbs_point_s prof_r   [128];
  logic [31:0]         acc_r    [`TBS_NREG][`TBS_NTAR + 1];
  logic [31:0]         acc_nxt  [`TBS_NREG][`TBS_NTAR + 1];
  logic [11:0]         ext_s1_r, ext_s2_r, ext_s3_r;
  logic [11:0]         ext_rise;
  logic [`TBS_NREG-1:0] pulse;
  logic [31:0]         inc      [`TBS_NREG];
  logic                acc_ph, wr_ok, err_c, dup_any_c;
  logic [33:0]         part_tot_c;
  tbs_pkg::tbs_cfg_s   wcfg;
  logic [31:0]         rdata_c;
  logic                pready_r, pslverr_r;
  logic [31:0]         prdata_r;
  tbs_pkg::tbs_state_e st_r, st_nxt;
  logic [4:0]          cidx_r, cidx_nxt, hidx_r, hidx_nxt;
  logic [2:0]          pidx_r, pidx_nxt, cand_r, cand_nxt, act_r, act_nxt;
  logic [1:0]          seas_r, seas_nxt, dtyp_r, dtyp_nxt;
  logic                hit_r, hit_nxt, first_r, m_hit;
  logic [6:0]          slot_prev_r;
  tbs_pkg::tbs_point_s pt;
  logic                log_r, log_nxt;
  logic [19:0]         fld_r, fld_nxt;
  logic [3:0]          sec_r, sec_nxt, tar_r, tar_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // External pulse inputs pass two flip-flops; the third finds rising edges.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_r <= 12'h000;
      ext_s2_r <= 12'h000;
      ext_s3_r <= 12'h000;
    end else begin
      ext_s1_r <= external_pulse_inputs;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  assign ext_rise = ext_s2_r & ~ext_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state, the write takes effect when pready is high.

  assign acc_ph = psel && penable;
  assign wr_ok  = acc_ph && pready_r && pwrite && !err_c;
  assign wcfg   = tbs_pkg::tbs_cfg_s'(pwdata);

  // Refusal checks and read data.
  always_comb begin
    dup_any_c  = 1'b0;
    err_c      = 1'b0;
    rdata_c    = 32'h0000_0000;
    part_tot_c = 34'h0;
    for (int i = 0; i < `TBS_NREG; i++) begin
      for (int j = i + 1; j < `TBS_NREG; j++) begin
        if (cfg_r[i].src != `TBS_SRC_NONE && cfg_r[i].src == cfg_r[j].src) dup_any_c = 1'b1;
      end
    end
    for (int f = 0; f < `TBS_NFILE; f++) begin
      if (paddr[11:4] == `TBS_A_PART && paddr[3:2] == 2'(f))
        part_tot_c = part_tot_c + {2'h0, pwdata};
      else
        part_tot_c = part_tot_c + {2'h0, part_r[f]};
    end
    if (paddr[11:4] == `TBS_A_CFG) begin
      rdata_c = cfg_r[paddr[3:2]];
      rdata_c[31:29] = (cfg_r[paddr[3:2]].src != `TBS_SRC_NONE) ? 3'(paddr[3:2]) + 3'h1 : 3'h0;
      if (pwrite) begin
        if (wcfg.src > `TBS_SRC_EXT_HI) err_c = 1'b1;
        if (is_ext(wcfg.src) && (wcfg.mult < `TBS_MULT_MIN || wcfg.mult > `TBS_MULT_MAX))
          err_c = 1'b1;
        for (int j = 0; j < `TBS_NREG; j++) begin
          if (2'(j) != paddr[3:2] && wcfg.src != `TBS_SRC_NONE && cfg_r[j].src == wcfg.src)
            err_c = 1'b1;
        end
      end
    end else if (paddr == `TBS_A_STATUS) begin
      rdata_c = {19'h0, hit_r, hidx_r, dtyp_r, seas_r, act_r};
      err_c   = pwrite;
    end else if (paddr == `TBS_A_LOGINFO) begin
      rdata_c = {24'h0, tar_r, sec_r};
      err_c   = pwrite;
    end else if (paddr[11:4] == `TBS_A_PART && paddr[3:2] != 2'h3) begin
      rdata_c = part_r[paddr[3:2]];
      err_c   = pwrite && (part_tot_c > `TBS_MEM_BYTES);
    end else if (paddr[11:7] == `TBS_A_CAL) begin
      rdata_c = cal_r[paddr[6:2]];
    end else if (paddr[11:9] == `TBS_A_PROF) begin
      rdata_c = {21'h0, prof_r[paddr[8:2]]};
    end else if (paddr[11:8] == `TBS_A_ACC && paddr[5:2] <= 4'h8) begin
      rdata_c = acc_r[paddr[7:6]][paddr[5:2]];
      err_c   = pwrite;
    end else begin
      err_c   = 1'b1;
    end
  end

  // Bus answer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= acc_ph && !pready_r;
      pslverr_r <= acc_ph && !pready_r && err_c;
      prdata_r  <= (acc_ph && !pready_r && !pwrite) ? rdata_c : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration words and log file partitions.

  always_comb begin
    cfg_nxt  = cfg_r;
    part_nxt = part_r;
    if (wr_ok && paddr[11:4] == `TBS_A_CFG) begin
      cfg_nxt[paddr[3:2]]        = wcfg;
      cfg_nxt[paddr[3:2]].target = 3'h0;
      if (!is_ext(wcfg.src)) begin
        cfg_nxt[paddr[3:2]].mult = `TBS_MULT_DEF;
        cfg_nxt[paddr[3:2]].unit = is_int(wcfg.src) ? auto_unit(wcfg.src)
                                                    : tbs_pkg::TBS_U_NONE;
      end
    end
    if (wr_ok && paddr[11:4] == `TBS_A_PART) part_nxt[paddr[3:2]] = pwdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `TBS_NREG; i++) cfg_r[i] <= `TBS_CFG_RST;
      for (int f = 0; f < `TBS_NFILE; f++) part_r[f] <= 32'h0000_0000;
    end else begin
      cfg_r  <= cfg_nxt;
      part_r <= part_nxt;
    end
  end

  // Calendar and profile memories; point 0 of each profile starts at midnight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < `TBS_NCAL; c++) cal_r[c] <= '0;
      for (int p = 0; p < 128; p++) prof_r[p] <= '0;
    end else if (wr_ok && paddr[11:7] == `TBS_A_CAL) begin
      cal_r[paddr[6:2]] <= tbs_pkg::tbs_cal_s'(pwdata);
    end else if (wr_ok && paddr[11:9] == `TBS_A_PROF) begin
      prof_r[paddr[8:2]]       <= tbs_pkg::tbs_point_s'(pwdata[10:0]);
      if (paddr[4:2] == 3'h0) prof_r[paddr[8:2]].start <= 7'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulation into totals and the active tariff register.

  always_comb begin
    acc_nxt = acc_r;
    for (int i = 0; i < `TBS_NREG; i++) begin
      inc[i]   = {15'h0000, cfg_r[i].mult};
      pulse[i] = 1'b0;
      if (is_int(cfg_r[i].src)) pulse[i] = int_pulse[3'(cfg_r[i].src - 5'h01)];
      if (is_ext(cfg_r[i].src)) pulse[i] = ext_rise[4'(cfg_r[i].src - 5'h06)];
      if (pulse[i]) begin
        acc_nxt[i][0] = acc_r[i][0] + inc[i];
        if (cfg_r[i].tariff_schedule_enable) acc_nxt[i][{1'b0, act_r} + 4'h1] =
                            acc_r[i][{1'b0, act_r} + 4'h1] + inc[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `TBS_NREG; i++)
        for (int t = 0; t <= `TBS_NTAR; t++) acc_r[i][t] <= 32'h0000_0000;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tariff evaluation: calendar scan, then profile scan, then one switch.

  tbs_cal_match u_match (
    .entry (cal_r[cidx_r]),
    .date  (rtc_date),
    .hit   (m_hit)
  );

  assign pt = prof_r[{seas_r, dtyp_r, pidx_r}];

  always_comb begin
    st_nxt = st_r;  cidx_nxt = cidx_r;  pidx_nxt = pidx_r;  cand_nxt = cand_r;
    act_nxt = act_r;  seas_nxt = seas_r;  dtyp_nxt = dtyp_r;
    hit_nxt = hit_r;  hidx_nxt = hidx_r;
    unique case (st_r)
      tbs_pkg::TBS_IDLE: ;
      tbs_pkg::TBS_CAL: begin
        if (m_hit || cidx_r == 5'h1F) begin
          seas_nxt = m_hit ? cal_r[cidx_r].season : 2'h0;
          dtyp_nxt = m_hit ? cal_r[cidx_r].dtype : 2'h0;
          hit_nxt  = m_hit;
          hidx_nxt = cidx_r;
          pidx_nxt = 3'h0;
          cand_nxt = 3'h0;
          st_nxt   = tbs_pkg::TBS_PROF;
        end else begin
          cidx_nxt = cidx_r + 5'h01;
        end
      end
      tbs_pkg::TBS_PROF: begin
        if ((pidx_r == 3'h0 || pt.valid) && pt.start <= rtc_date.slot)
          cand_nxt = pt.tariff;
        if (pidx_r == 3'h7) st_nxt = tbs_pkg::TBS_DONE;
        else pidx_nxt = pidx_r + 3'h1;
      end
      tbs_pkg::TBS_DONE: begin
        act_nxt = cand_r;
        st_nxt  = tbs_pkg::TBS_IDLE;
      end
    endcase
    if (first_r || rtc_date.slot != slot_prev_r) begin
      st_nxt   = tbs_pkg::TBS_CAL;
      cidx_nxt = 5'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= tbs_pkg::TBS_IDLE;  cidx_r <= 5'h00;  pidx_r <= 3'h0;  cand_r <= 3'h0;
      act_r <= 3'h0;  seas_r <= 2'h0;  dtyp_r <= 2'h0;  hit_r <= 1'b0;  hidx_r <= 5'h00;
      first_r <= 1'b1;  slot_prev_r <= 7'h00;
    end else begin
      st_r <= st_nxt;  cidx_r <= cidx_nxt;  pidx_r <= pidx_nxt;  cand_r <= cand_nxt;
      act_r <= act_nxt;  seas_r <= seas_nxt;  dtyp_r <= dtyp_nxt;  hit_r <= hit_nxt;
      hidx_r <= hidx_nxt;  first_r <= 1'b0;  slot_prev_r <= rtc_date.slot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Daily billing profile record layout, issued at midnight.

  always_comb begin
    log_nxt = (rtc_date.slot == 7'h00) && (slot_prev_r != 7'h00) && !first_r;
    fld_nxt = 20'h00000;
    sec_nxt = 4'h0;
    tar_nxt = 4'h1;
    for (int i = 0; i < `TBS_NREG; i++) begin
      if (cfg_r[i].src != `TBS_SRC_NONE) begin
        fld_nxt[5*i]   = cfg_r[i].use_prof;
        fld_nxt[5*i+1] = cfg_r[i].use_prof && cfg_r[i].tariff_schedule_enable;
        fld_nxt[5*i+2] = cfg_r[i].dmd_prof;
        fld_nxt[5*i+3] = cfg_r[i].dmd_prof && cfg_r[i].tariff_schedule_enable;
        fld_nxt[5*i+4] = cfg_r[i].sum_prof;
        sec_nxt = sec_nxt + (cfg_r[i].dmd_prof ? 4'h2 : 4'h1);
      end
    end
    for (int p = 0; p < 128; p++) begin
      if ((p % 8 == 0 || prof_r[p].valid) && {1'b0, prof_r[p].tariff} + 4'h1 > tar_nxt)
        tar_nxt = {1'b0, prof_r[p].tariff} + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_r <= 1'b0;  fld_r <= 20'h00000;  sec_r <= 4'h0;  tar_r <= 4'h1;
    end else begin
      log_r <= log_nxt;  fld_r <= fld_nxt;  sec_r <= sec_nxt;  tar_r <= tar_nxt;
    end
  end

  assign prdata = prdata_r;  assign pready = pready_r;  assign pslverr = pslverr_r;
  assign active_tariff = act_r;  assign log_strobe = log_r;  assign log_fields = fld_r;
  assign log_sections = sec_r;  assign log_tariffs = tar_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and cover points.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  total_accum_a: assert property (pulse[0] |=> acc_r[0][0] == $past(acc_r[0][0]) + $past(inc[0]))
    else $error("Total did not grow by the multiplier.");
  no_tou_a: assert property ((pulse[0] && !cfg_r[0].tariff_schedule_enable) |=> acc_r[0][1] == $past(acc_r[0][1]))
    else $error("Tariff register moved with tariff option off.");
  log_energy_a: assert property ((log_r && $past(cfg_r[0].src) != 5'h00) |->
      fld_r[0] == $past(cfg_r[0].use_prof) &&
      fld_r[1] == ($past(cfg_r[0].use_prof) && $past(cfg_r[0].tariff_schedule_enable)))
    else $error("Energy fields of the record are wrong.");
  log_demand_a: assert property ((log_r && $past(cfg_r[1].src) != 5'h00) |->
      fld_r[7] == $past(cfg_r[1].dmd_prof) &&
      fld_r[8] == ($past(cfg_r[1].dmd_prof) && $past(cfg_r[1].tariff_schedule_enable)))
    else $error("Demand fields of the record are wrong.");
  log_summary_a: assert property ((log_r && $past(cfg_r[2].src) != 5'h00) |->
      fld_r[14] == $past(cfg_r[2].sum_prof))
    else $error("Summary field of the record is wrong.");
  unit_auto_a: assert property (is_int(cfg_r[1].src) |-> cfg_r[1].unit == auto_unit(cfg_r[1].src))
    else $error("Internal source unit not set automatically.");
  mult_range_a: assert property (cfg_r[2].mult >= `TBS_MULT_MIN && cfg_r[2].mult <= `TBS_MULT_MAX
      && (is_ext(cfg_r[2].src) || cfg_r[2].mult == `TBS_MULT_DEF))
    else $error("Multiplier out of range or changed for internal source.");
  src_unique_a: assert property (!dup_any_c)
    else $error("Source linked to two billing registers.");
  cal_scan_a: assert property ((st_r == tbs_pkg::TBS_CAL && $past(st_r) != tbs_pkg::TBS_CAL) |->
      ##[1:32] st_r != tbs_pkg::TBS_CAL)
    else $error("Calendar scan did not finish.");
  tariff_switch_a: assert property ((act_r != $past(act_r)) |-> $past(st_r) == tbs_pkg::TBS_DONE)
    else $error("Tariff changed outside an evaluation.");
  part_fit_a: assert property ({2'h0, part_r[0]} + {2'h0, part_r[1]} + {2'h0, part_r[2]}
      <= `TBS_MEM_BYTES)
    else $error("Log files exceed the memory.");

  tou_pulse_c: cover property (pulse[0] && cfg_r[0].tariff_schedule_enable && act_r != 3'h0);
  cal_hit_c: cover property (st_r == tbs_pkg::TBS_CAL && m_hit && cidx_r != 5'h00);
  tariff_chg_c: cover property (act_r != $past(act_r));
  midnight_c: cover property (log_r && fld_r[2]);

endmodule : tbs_top

// file: rtl/tbs_consts.svh
`ifndef TBS_CONSTS_SVH
`define TBS_CONSTS_SVH

// Block dimensions.
`define TBS_NREG        4
`define TBS_NTAR        8
`define TBS_NPT         8
`define TBS_NCAL        32
`define TBS_NINT        5
`define TBS_NEXT        12
`define TBS_SLOT_MIN    15

// Source codes: 0 none, 1..5 internal energies, 6..17 external pulse inputs.
`define TBS_SRC_NONE    5'h00
`define TBS_SRC_INT_LO  5'h01
`define TBS_SRC_INT_HI  5'h05
`define TBS_SRC_EXT_LO  5'h06
`define TBS_SRC_EXT_HI  5'h11

// Multiplier in thousandths.
`define TBS_MULT_MIN    17'h00001
`define TBS_MULT_MAX    17'h186A0
`define TBS_MULT_DEF    17'h003E8

// Log memory in bytes (125 KByte) shared among the three files.
`define TBS_MEM_BYTES   34'h00001F400
`define TBS_NFILE       3

// Configuration word reset value: profile use and summary set, unit none.
`define TBS_CFG_RST     32'h003E8140

// Register map: byte addresses for status and log info, upper address bits for the other blocks.
`define TBS_A_CFG       8'h00
`define TBS_A_STATUS    12'h010
`define TBS_A_LOGINFO   12'h014
`define TBS_A_PART      8'h02
`define TBS_A_CAL       5'h01
`define TBS_A_PROF      3'h1
`define TBS_A_ACC       4'h4

`endif

// file: rtl/tbs_pkg.sv
package tbs_pkg;

  // Measurement units of a billing register.
  typedef enum logic [2:0] {
    TBS_U_NONE  = 3'h0,
    TBS_U_KWH   = 3'h1,
    TBS_U_KVARH = 3'h2,
    TBS_U_KVAH  = 3'h3,
    TBS_U_M3    = 3'h4,
    TBS_U_CF    = 3'h5,
    TBS_U_CCF   = 3'h6
  } tbs_unit_e;

  // Evaluation sequencer, Gray coded along the scan.
  typedef enum logic [1:0] {
    TBS_IDLE = 2'h0,
    TBS_CAL  = 2'h1,
    TBS_PROF = 2'h3,
    TBS_DONE = 2'h2
  } tbs_state_e;

  // Billing register configuration word.
  typedef struct packed {
    logic [2:0]  target;
    logic [16:0] mult;
    tbs_unit_e   unit;
    logic        sum_prof;
    logic        dmd_prof;
    logic        use_prof;
    logic        tariff_schedule_enable;
    logic [4:0]  src;
  } tbs_cfg_s;

  // Calendar entry; zero in a month, weekday, day or week field means any value.
  typedef struct packed {
    logic [4:0] rsv;
    logic       valid;
    logic [2:0] week;
    logic [4:0] mday;
    logic [3:0] mon_end;
    logic [3:0] mon_start;
    logic [2:0] wd_end;
    logic [2:0] wd_start;
    logic [1:0] dtype;
    logic [1:0] season;
  } tbs_cal_s;

  // Tariff change point; start is a 15-minute slot of the day.
  typedef struct packed {
    logic       valid;
    logic [2:0] tariff;
    logic [6:0] start;
  } tbs_point_s;

  // Present date and slot from the device clock.
  typedef struct packed {
    logic [3:0] month;
    logic [4:0] mday;
    logic [2:0] wday;
    logic [6:0] slot;
  } tbs_date_s;

endpackage : tbs_pkg

// file: rtl/tbs_cal_match.sv
`timescale 1ns/100ps
module tbs_cal_match (
  input  tbs_pkg::tbs_cal_s  entry,
  input  tbs_pkg::tbs_date_s date,
  output logic               hit
);

  // A blank bound matches all; a start above the end wraps around.
  function automatic logic in_range(input logic [3:0] v, input logic [3:0] a,
                                    input logic [3:0] b);
    if (a == 4'h0 || b == 4'h0) return 1'b1;
    if (a <= b) return (v >= a) && (v <= b);
    return (v >= a) || (v <= b);
  endfunction : in_range

  logic [4:0] wom;
  logic       mon_ok;
  logic       wd_ok;
  logic       md_ok;
  logic       wk_ok;

  // Entry match: month and weekday ranges, then the exception day.
  always_comb begin
    wom    = 5'((date.mday - 5'h01) / 5'h07 + 5'h01);
    mon_ok = in_range(date.month, entry.mon_start, entry.mon_end);
    wd_ok  = (entry.week != 3'h0) ||
             in_range({1'b0, date.wday}, {1'b0, entry.wd_start}, {1'b0, entry.wd_end});
    md_ok  = (entry.mday == 5'h00) || (entry.mday == date.mday);
    wk_ok  = (entry.week == 3'h0) ||
             ((wom[2:0] == entry.week) && (date.wday == entry.wd_start));
    hit    = entry.valid && mon_ok && wd_ok && md_ok && wk_ok;
  end

endmodule : tbs_cal_match

// file: bench/tbs_src_model.sv
`timescale 1ns/100ps
module tbs_src_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [4:0]  int_req,
  input  wire logic [11:0] ext_req,
  output logic      [4:0]  int_pulse,
  output logic      [11:0] external_pulse_inputs
);
  logic [3:0]  cnt_r;
  logic [11:0] sel_r;

  // Internal increments last one cycle; a contact pulse is held 4 high, then at least 12 low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_pulse             <= 5'h00;
      external_pulse_inputs <= 12'h000;
      cnt_r                 <= 4'h0;
      sel_r                 <= 12'h000;
    end else begin
      int_pulse <= int_req;
      if (cnt_r == 4'h0 && ext_req != 12'h000) begin
        sel_r <= ext_req;
        cnt_r <= 4'h1;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r + 4'h1;
      end
      external_pulse_inputs <= (cnt_r != 4'h0 && cnt_r < 4'h5) ? sel_r : 12'h000;
    end
  end
endmodule : tbs_src_model

// file: bench/tariff_billing_scheduler_test.sv
`timescale 1ns/100ps
module tariff_billing_scheduler_test;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = 32'h0, prdata, q;
  logic               pready, pslverr, e, log_strobe;
  logic [4:0]         int_pulse, int_req = 5'h00;
  logic [11:0]        external_pulse_inputs, ext_req = 12'h000;
  logic [2:0]         active_tariff;
  logic [19:0]        log_fields;
  logic [3:0]         log_sections, log_tariffs;
  tbs_pkg::tbs_date_s rtc_date = '{4'h1, 5'h01, 3'h1, 7'h00};
  int                 failures = 0, n_compared = 0, cyc = 0;

  always #2 pclk = ~pclk;

  tbs_top u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .int_pulse, .external_pulse_inputs, .rtc_date, .active_tariff,
    .log_strobe, .log_fields, .log_sections, .log_tariffs);
  tbs_src_model u_src (.pclk, .presetn, .int_req, .ext_req, .int_pulse,
    .external_pulse_inputs);

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic wrap_up();
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is sampled high or 16 cycles pass.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic x);
    apb(1'b1, a, d);
    chk($sformatf("pslverr at %h", a), {31'h0, e}, {31'h0, x});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("word at %h", a), q, x);
  endtask : rd

  // New month and slot; evaluation settles within about 43 cycles.
  task automatic date(input logic [3:0] m, input logic [6:0] s);
    @(posedge pclk);
    rtc_date <= '{m, 5'h01, 3'h1, s};
    repeat (60) @(posedge pclk);
  endtask : date

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    rd(12'h000, 32'h003E8140);
    wr(12'h02C, 32'h0, 1'b1);
    chk("log_tariffs", {28'h0, log_tariffs}, 32'h1);
  endtask : t_reset

  task automatic t_link();
    wr(12'h000, 32'h013881E1, 1'b0);
    rd(12'h000, 32'h203E83E1);
    wr(12'h004, 32'h003E8001, 1'b1);
    wr(12'h004, 32'h00000846, 1'b1);
    wr(12'h004, 32'h186A0846, 1'b0);
    rd(12'h004, 32'h586A0846);
    wr(12'h008, 32'h003E8152, 1'b1);
    wr(12'h010, 32'h0, 1'b1);
    repeat (3) @(posedge pclk);
    chk("log_fields", {12'h0, log_fields}, 32'h3F);
    chk("log_sections", {28'h0, log_sections}, 32'h3);
  endtask : t_link

  task automatic t_tariff();
    int k;
    k = 0;
    wr(12'h200, 32'h00000500, 1'b0);
    wr(12'h204, 32'h00000684, 1'b0);
    date(4'h1, 7'h03);
    chk("tariff slot 3", {29'h0, active_tariff}, 32'h2);
    date(4'h1, 7'h04);
    chk("tariff slot 4", {29'h0, active_tariff}, 32'h5);
    chk("log_tariffs", {28'h0, log_tariffs}, 32'h6);
    @(posedge pclk);
    int_req <= 5'h01;
    ext_req <= 12'h001;
    @(posedge pclk);
    int_req <= 5'h00;
    ext_req <= 12'h000;
    repeat (20) @(posedge pclk);
    rd(12'h400, 32'h000003E8);
    rd(12'h418, 32'h000003E8);
    rd(12'h440, 32'h000186A0);
    date(4'h1, 7'h5F);
    chk("tariff slot 95", {29'h0, active_tariff}, 32'h5);
    @(posedge pclk);
    rtc_date <= '{4'h1, 5'h01, 3'h1, 7'h00};
    repeat (4) begin
      @(posedge pclk);
      if (log_strobe === 1'b1) k++;
    end
    chk("log_strobe count", k, 32'h1);
    repeat (60) @(posedge pclk);
    chk("tariff midnight", {29'h0, active_tariff}, 32'h2);
  endtask : t_tariff

  task automatic t_cal();
    wr(12'h080, 32'h0400AC01, 1'b0);
    wr(12'h084, 32'h04000002, 1'b0);
    date(4'h1, 7'h05);
    rd(12'h010, 32'h00001008);
    date(4'h5, 7'h06);
    rd(12'h010, 32'h00001090);
  endtask : t_cal

  task automatic t_extra();
    wr(12'h020, 32'h0001F400, 1'b0);
    wr(12'h024, 32'h00000001, 1'b1);
    rd(12'h024, 32'h00000000);
    wr(12'h080, 32'h0480CC13, 1'b0);
    date(4'h3, 7'h07);
    rd(12'h010, 32'h00001018);
    date(4'h4, 7'h08);
    rd(12'h010, 32'h00001090);
  endtask : t_extra

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence and hang guard.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_link();
    t_tariff();
    t_cal();
    t_extra();
    wrap_up();
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
endmodule : tariff_billing_scheduler_test
